// >>> hw/psr_defines.svh
// Purpose: Constants for the pipelined burst SRAM pin control block.
// Assumes: Included by the package and the design module.
// Notes: Widths fixed; one byte lane carries eight data bits and one parity bit.
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

`define PSR_LANES 4
`define PSR_BYTE_W 8
`define PSR_DATA_W 32
`define PSR_ADDR_W 10
`define PSR_DEPTH 1024
`define PSR_BURST_LSB 0
`define PSR_BURST_MSB 1

`endif

// >>> hw/psr_pkg.sv
// Purpose: Types for the pipelined burst SRAM pin control block.
// Assumes: psr_defines.svh supplies all widths.
// Notes: Synchronous control pins travel as one packed struct.
`include "psr_defines.svh"
package psr_pkg;

    typedef struct packed {
        logic clock_qualify_n;
        logic chip_select_first_n;
        logic chip_select_second;
        logic chip_select_third_n;
        logic write_enable_n;
        logic advance_or_load;
        logic [`PSR_LANES-1:0] byte_write_select_n;
        logic [`PSR_ADDR_W-1:0] addr;
    } psr_ctrl_t;

    typedef struct packed {
        logic [`PSR_LANES-1:0] parity_data_lines;
        logic [`PSR_DATA_W-1:0] data;
    } psr_bus_t;

    typedef enum logic [2:0] {
        PSR_IDLE = 3'h1,
        PSR_READ = 3'h2,
        PSR_WRITE = 3'h4
    } psr_op_t;

endpackage : psr_pkg

// >>> hw/psr_sram.sv
// Purpose: Pipelined burst SRAM core with pin-level control behaviour.
// Assumes: All synchronous inputs, tck and tdi sampled on clk as plain inputs.
// Notes: Output enable acts combinationally on the data drive enable.
// Functional notes
// R1 - Clock edge counts only when qualify low
// R2 - Qualify high stretches cycle, never deselects
// R3 - First select active low, sampled qualified
// R4 - Second select active high, sampled qualified
// R5 - Third select active low; all three select
// R6 - Output enable low permits driving data
// R7 - Tristate on write data, reselect, deselect
// R8 - Input data captured on qualified edge
// R9 - Read data appears one cycle later
// R10 - Parity lines follow their lane's byte write
// R11 - Strap high interleaved, low linear
// R12 - Floating strap treated as high
// R13 - Strap held constant during operation
// R14 - Test output changes on clock falling
// R15 - Test input sampled on clock rising
// R16 - Write enable low starts a write
// R17 - Byte write select gates its lane
// R18 - Advance high bursts, low loads address
`timescale 1ns/1ns
`include "psr_defines.svh"
module psr_sram
    import psr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire psr_ctrl_t ctrl,
    input wire logic output_enable_n,
    input wire logic burst_mode,
    input wire logic burst_mode_driven,
    input wire psr_bus_t dq_in,
    output psr_bus_t dq_out,
    output logic dq_oe,
    input wire logic tck,
    input wire logic tdi,
    output logic tdo
);

    // ****************************************
    // Burst order
    // ****************************************
    function automatic logic [1:0] psr_next_burst(input logic [1:0] start, input logic [1:0] cnt, input logic inter);
        psr_next_burst = inter ? (start ^ cnt) : (start + cnt);
    endfunction : psr_next_burst

    psr_bus_t mem_q [0:`PSR_DEPTH-1];
    psr_op_t op_q;
    logic sel_prev_q;
    logic first_q;
    logic [`PSR_ADDR_W-1:0] base_q;
    logic [1:0] cnt_q;
    logic [`PSR_LANES-1:0] bw_q;
    logic is_write_q;
    logic [`PSR_ADDR_W-1:0] wr_addr_q;
    psr_bus_t wr_data_q;
    logic [`PSR_LANES-1:0] wr_bw_q;
    logic wr_pend_q;
    logic mode_q;
    logic tck_q;
    logic tdi_q;
    logic tdo_q;

    logic qual;
    logic sel;
    logic mode_eff;
    logic [`PSR_ADDR_W-1:0] cur_addr;

    assign qual = ~ctrl.clock_qualify_n; // R1 R2
    assign sel = ~ctrl.chip_select_first_n & ctrl.chip_select_second & ~ctrl.chip_select_third_n; // R3 R4 R5
    assign mode_eff = burst_mode_driven ? burst_mode : 1'b1; // R11 R12
    assign cur_addr = {base_q[`PSR_ADDR_W-1:`PSR_BURST_MSB+1],
                       psr_next_burst(base_q[`PSR_BURST_MSB:`PSR_BURST_LSB], cnt_q, mode_q)};

    // ****************************************
    // Strap capture
    // ****************************************
    // Caught on every clock while reset is high; strap must not move afterwards
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= mode_eff; // R13
        end
    end

    // ****************************************
    // Access control
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            op_q <= PSR_IDLE;
            sel_prev_q <= 1'b0;
            first_q <= 1'b0;
            base_q <= '0;
            cnt_q <= 2'h0;
            bw_q <= '1;
            is_write_q <= 1'b0;
        end else if (qual) begin // R1
            if (!ctrl.advance_or_load) begin // R18
                sel_prev_q <= sel;
                first_q <= sel & ~sel_prev_q; // R7
                if (sel) begin
                    base_q <= ctrl.addr;
                    cnt_q <= 2'h0;
                    is_write_q <= ~ctrl.write_enable_n; // R16
                    bw_q <= ctrl.byte_write_select_n; // R17
                    op_q <= ctrl.write_enable_n ? PSR_READ : PSR_WRITE;
                end else begin
                    op_q <= PSR_IDLE;
                end
            end else begin
                first_q <= 1'b0;
                if (sel_prev_q) begin
                    cnt_q <= cnt_q + 2'h1; // R18
                    bw_q <= ctrl.byte_write_select_n; // R17
                    op_q <= is_write_q ? PSR_WRITE : PSR_READ;
                end
            end
        end
    end

    // ****************************************
    // Data path
    // ****************************************
    // Write data arrives one cycle after its address
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            wr_bw_q <= '1;
        end else if (qual) begin
            wr_pend_q <= (op_q == PSR_WRITE);
            wr_addr_q <= cur_addr;
            wr_bw_q <= bw_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_data_q <= '0;
        end else if (qual) begin
            wr_data_q <= dq_in; // R8
        end
    end

    always_ff @(posedge clk) begin
        if (!reset && qual && op_q == PSR_WRITE) begin
            for (int i = 0; i < `PSR_LANES; i++) begin
                if (!bw_q[i]) begin // R10 R17
                    mem_q[cur_addr].data[i*`PSR_BYTE_W +: `PSR_BYTE_W] <= dq_in.data[i*`PSR_BYTE_W +: `PSR_BYTE_W];
                    mem_q[cur_addr].parity_data_lines[i] <= dq_in.parity_data_lines[i]; // R10
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dq_out <= '0;
        end else if (qual && op_q == PSR_READ) begin
            dq_out <= mem_q[cur_addr]; // R9
        end
    end

    logic rd_valid_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
        end else if (qual) begin
            rd_valid_q <= (op_q == PSR_READ) && !first_q; // R7
        end
    end

    // ****************************************
    // Drive permission by operation
    // ****************************************
    // Deselect still drains the last read for one cycle
    logic op_drives;
    always_comb begin
        op_drives = 1'b0;
        case (op_q)
            PSR_IDLE: begin
                op_drives = 1'b1;
            end
            PSR_READ: begin
                op_drives = 1'b1;
            end
            PSR_WRITE: begin
                op_drives = 1'b0; // R7
            end
            default: begin
                op_drives = 1'b0;
            end
        endcase
    end

    // Bus contention avoided: write data cycle never driven
    assign dq_oe = rd_valid_q & ~output_enable_n & op_drives; // R6 R7

    // ****************************************
    // Test port edges
    // ****************************************
    // Edges of tck found by sampling on clk; tck must be slow
    always_ff @(posedge clk) begin
        if (reset) begin
            tck_q <= 1'b0;
            tdi_q <= 1'b0;
            tdo_q <= 1'b0;
        end else begin
            tck_q <= tck;
            if (tck && !tck_q) begin
                tdi_q <= tdi; // R15
            end
            if (!tck && tck_q) begin
                tdo_q <= tdi_q; // R14
            end
        end
    end

    assign tdo = tdo_q;

endmodule : psr_sram

// >>> dv/psr_sram_asserts.sv
// Purpose: Pin timing checks on psr_sram.
// Assumes: Bound to the psr_sram ports.
// Notes: Deselect checks use loads only.
`timescale 1ns/1ns
module psr_sram_asserts
    import psr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire psr_ctrl_t ctrl,
    input wire logic output_enable_n,
    input wire psr_bus_t dq_out,
    input wire logic dq_oe,
    input wire logic tck,
    input wire logic tdo
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic go;
    logic sel;
    assign go = !ctrl.clock_qualify_n && !ctrl.advance_or_load;
    assign sel = !ctrl.chip_select_first_n && ctrl.chip_select_second && !ctrl.chip_select_third_n;
    sequence s_drop(x);
        go && x ##1 !ctrl.clock_qualify_n;
    endsequence
    a_cs1_off: assert property (s_drop(ctrl.chip_select_first_n) |=> !dq_oe) else $error("cs1");
    a_cs2_off: assert property (s_drop(!ctrl.chip_select_second) |=> !dq_oe) else $error("cs2");
    a_cs3_off: assert property (s_drop(ctrl.chip_select_third_n) |=> !dq_oe) else $error("cs3");
    a_wr_float: assert property (go && sel && !ctrl.write_enable_n |=> !dq_oe) else $error("wr");
    a_oe_gate: assert property (output_enable_n |-> !dq_oe) else $error("oe");
    a_hold_out: assert property (ctrl.clock_qualify_n |=> $stable(dq_out)) else $error("hold");
    a_stretch_on: assert property (dq_oe && ctrl.clock_qualify_n ##1 !output_enable_n |-> dq_oe) else $error("st");
    a_tdo_edge: assert property ($changed(tdo) |-> !tck) else $error("tdo");
endmodule : psr_sram_asserts
bind psr_sram psr_sram_asserts i_psr_sram_asserts (.clk, .reset, .ctrl, .output_enable_n, .dq_out, .dq_oe, .tck, .tdo);

// >>> dv/psr_ctl_model.sv
// Purpose: Controller side of the SRAM bus.
// Assumes: Pins change at the falling edge.
// Notes: Idle data bus shows inverted last value.
`timescale 1ns/1ns
module psr_ctl_model
    import psr_pkg::*;
(
    input wire logic clk,
    output psr_ctrl_t ctrl,
    output psr_bus_t dq
);
    logic wp = 1'h0;
    psr_bus_t wd;
    initial ctrl = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 4'hF, 10'h000};
    initial dq = 36'h0;
    task automatic op(input logic q, input logic [2:0] c, input logic w, input logic [3:0] bw,
                      input logic [9:0] a, input psr_bus_t d);
        @(negedge clk);
        if (!q) begin
            dq <= wp ? wd : ~dq;
            wp = w && c == 3'h2;
            wd = d;
        end
        ctrl <= '{q, c[2], c[1], c[0], !w, 1'h0, bw, a};
    endtask : op
    // Burst step: keeps selects, advances the counter
    task automatic adv(input psr_bus_t d);
        @(negedge clk);
        dq <= wp ? wd : ~dq;
        wd = d;
        ctrl.advance_or_load <= 1'h1;
    endtask : adv
endmodule : psr_ctl_model

// >>> dv/psr_sram_tb.sv
// Purpose: Self-checking bench for psr_sram.
// Assumes: Reference memory kept in the bench.
// Notes: Strap left floating; one interleaved write burst and one read burst run.
`timescale 1ns/1ns
module psr_sram_tb
    import psr_pkg::*;
;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic output_enable_n = 1'h0;
    logic tck = 1'h0;
    logic tdi = 1'h0;
    logic tdo;
    logic dq_oe;
    psr_ctrl_t ctrl;
    psr_bus_t dq_in;
    psr_bus_t dq_out;
    logic [15:0] r = 16'h0012;
    logic [35:0] mem [int];
    logic [2:0] sel_tab [6] = '{3'h2, 3'h6, 3'h0, 3'h3, 3'h2, 3'h2};
    int num_errors = 0;
    int check_count = 0;
    always #2 clk = ~clk;
    psr_ctl_model i_psr_ctl_model (.clk, .ctrl, .dq(dq_in));
    psr_sram i_psr_sram (.clk, .reset, .ctrl, .output_enable_n, .burst_mode(1'h1), .burst_mode_driven(1'h0),
        .dq_in, .dq_out, .dq_oe, .tck, .tdi, .tdo);
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nx
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
    initial begin
        logic [9:0] a;
        logic [3:0] bw;
        psr_bus_t d;
        logic [35:0] m;
        logic [9:0] b;
        psr_bus_t dk [4];
        repeat (8) @(posedge clk);
        @(negedge clk) reset = 1'h0;
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 6; j++) begin
                r = nx(r);
                if (j == 0) a = r[9:0];
                bw = j == 0 ? 4'h0 : r[3:0];
                d = {r[15:12], r, nx(r)};
                m = mem.exists(a) ? mem[a] : 36'h0;
                for (int k = 0; k < 4; k++) begin
                    if ((j == 0 || j == 5) && !bw[k]) begin
                        m[8*k+:8] = d[8*k+:8];
                        m[32+k] = d[32+k];
                    end
                end
                mem[a] = m;
                i_psr_ctl_model.op(j == 4, sel_tab[j], 1'h1, bw, a, d);
                i_psr_ctl_model.op(1'h0, 3'h2, 1'h0, 4'hF, a, d);
                i_psr_ctl_model.op(1'h0, 3'h2, 1'h0, 4'hF, a, d);
                i_psr_ctl_model.op(1'h1, 3'h2, 1'h0, 4'hF, a, d);
                chk("dq_oe reselect", {35'h0, j == 0 || j == 5}, {35'h0, dq_oe});
                i_psr_ctl_model.op(1'h0, 3'h0, 1'h0, 4'hF, a, d);
                output_enable_n = r[0];
                i_psr_ctl_model.op(1'h0, 3'h0, 1'h0, 4'hF, a, d);
                chk("read data", mem[a], dq_out);
                chk("dq_oe", {35'h0, ~r[0]}, {35'h0, dq_oe});
                output_enable_n = 1'h0;
            end
        end
        $display("test rw done");
        r = nx(r);
        b = r[9:0];
        for (int k = 0; k < 4; k++) begin
            r = nx(r);
            dk[k] = {r[15:12], r, nx(r)};
            mem[b ^ 10'(k)] = dk[k];
        end
        i_psr_ctl_model.op(1'h0, 3'h2, 1'h1, 4'h0, b, dk[0]);
        for (int k = 1; k < 4; k++) begin
            i_psr_ctl_model.adv(dk[k]);
        end
        i_psr_ctl_model.op(1'h0, 3'h2, 1'h0, 4'hF, b, dk[0]);
        i_psr_ctl_model.adv(dk[0]);
        for (int k = 0; k < 4; k++) begin
            i_psr_ctl_model.adv(dk[0]);
            chk("burst data", mem[b ^ 10'(k)], dq_out);
        end
        i_psr_ctl_model.op(1'h0, 3'h0, 1'h0, 4'hF, b, dk[0]);
        $display("test burst done");
        for (int k = 0; k < 8; k++) begin
            r = nx(r);
            @(negedge clk) tdi = r[0];
            tck = 1'h1;
            repeat (3) @(negedge clk);
            tdi = ~r[0];
            tck = 1'h0;
            repeat (3) @(negedge clk);
            chk("tdo", {35'h0, r[0]}, {35'h0, tdo});
        end
        $display("test tdo done");
        summarize();
    end
endmodule : psr_sram_tb
